// ### rtl/sfd_pkg.sv
// constants and types shared by the serial full-duplex transfer block
package sfd_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_DATA = 8'h04;
   localparam logic [7:0] OFS_STAT = 8'h08;
   localparam logic [7:0] OFS_ISTAT = 8'h0C;
   localparam logic [7:0] OFS_ICLR = 8'h10;
   localparam logic [7:0] OFS_IEN = 8'h14;

   // serial_control_one field positions
   localparam int CTRL_START = 7;
   localparam int CTRL_ABORT = 6;
   localparam int CTRL_MODE_LO = 4;
   localparam int CTRL_SCK_LO = 0;
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [7:0] CTRL_STORE_MASK = 8'hB7;

   // serial_status_reg field positions
   localparam int STAT_ACTIVE = 0;
   localparam int STAT_WAIT = 1;
   localparam int STAT_RD_PEND = 2;
   localparam int STAT_WR_PEND = 3;

   // interrupt status/enable/clear bit positions
   localparam int IRQ_BYTE = 0;
   localparam int IRQ_END = 1;
   localparam int IRQ_BITS = 2;

   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [2:0] SCK_EXT = 3'h7;
   localparam logic [2:0] LAST_BIT = 3'h7;
   localparam int DIV_BASE_DEF = 4;

   typedef enum logic [1:0] {
      MODE_TX = 2'h0,
      MODE_RSV = 2'h1,
      MODE_TRX = 2'h2,
      MODE_RX = 2'h3
   } sfd_mode_t;

   // gray order idle -> shift -> wait
   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_SHIFT = 2'h1,
      ST_WAIT = 2'h3
   } sfd_state_t;
endpackage : sfd_pkg

// ### rtl/sfd_sync.sv
// two-flop synchroniser for pin inputs
`timescale 1ns/1ns
`default_nettype none
module sfd_sync #(
   parameter int W = 1
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   if (W < 1) begin : g_bad_width
      $error("sfd_sync width must be at least 1");
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule : sfd_sync
`default_nettype wire

// ### rtl/sfd_clkgen.sv
// half-period tick divider for the internal serial clock
`timescale 1ns/1ns
`default_nettype none
module sfd_clkgen #(
   parameter int DIV_BASE = sfd_pkg::DIV_BASE_DEF
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic run,
   input wire logic [2:0] sel,
   output logic tick
);
   logic [15:0] cnt_q;
   wire [15:0] limit;

   // largest half period is DIV_BASE * 64 cycles, must fit the counter
   if (DIV_BASE < 1 || DIV_BASE > 1023) begin : g_bad_div
      $error("sfd_clkgen DIV_BASE out of range");
   end

   function automatic logic [15:0] half_limit(input logic [2:0] s);
      half_limit = 16'(DIV_BASE << s) - 16'h0001;
   endfunction : half_limit

   assign limit = half_limit(sel);
   assign tick = run && (cnt_q >= limit);

   // counter restarts whenever the clock is parked
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnt_q <= 16'h0000;
      end else if (!run || tick) begin
         cnt_q <= 16'h0000;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end
endmodule : sfd_clkgen
`default_nettype wire

// ### rtl/sfd_top.sv
// clocked serial full-duplex transfer unit with register port
// Notes on behaviour
// - drive on falling, sample on rising, lsb
// - after eight bits, buffer gets byte (not in tx mode), irq
// - internal clock waits for the read and/or write its mode needs
// - old last bit held until first fall
// - cleared start finishes current byte first
// - abort stops at once, clears active
// - active flag clears when stop completes
// - mode change discards buffer contents
// - last bit held on serial out after end
// - select 111 means external clock in
// - internal clock pin high at start
// - mode field picks tx, rx or both
`timescale 1ns/1ns
`default_nettype none
module sfd_top #(
   parameter int DIV_BASE = sfd_pkg::DIV_BASE_DEF
) (
   input wire logic clk_sys,
   input wire logic rstn,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   output logic buffer_irq,
   input wire logic serial_clock_pin_i,
   output logic serial_clock_pin_o,
   output logic serial_clock_pin_oe_n,
   output logic serial_out_pin,
   input wire logic serial_in_pin
);
   sfd_pkg::sfd_state_t state_q, state_d;
   logic [7:0] serial_control_one;
   logic [7:0] shared_data_buffer;
   logic [7:0] tx_shift_q;
   logic [7:0] rx_shift_q;
   logic [2:0] bit_cnt_q;
   logic xfer_active_flag;
   logic rd_pend_q;
   logic wr_pend_q;
   logic sck_q;
   logic sck_prev_q;
   logic so_q;
   logic [sfd_pkg::IRQ_BITS-1:0] irq_stat_q;
   logic [sfd_pkg::IRQ_BITS-1:0] irq_en_q;
   logic [31:0] rdata_q;
   logic sck_s;
   logic si_s;
   logic tick;

   // register decode
   wire wr_ctrl = reg_wr && (reg_addr == sfd_pkg::OFS_CTRL);
   wire wr_data = reg_wr && (reg_addr == sfd_pkg::OFS_DATA);
   wire rd_data = reg_rd && (reg_addr == sfd_pkg::OFS_DATA);
   wire wr_iclr = reg_wr && (reg_addr == sfd_pkg::OFS_ICLR);
   wire wr_ien = reg_wr && (reg_addr == sfd_pkg::OFS_IEN);

   wire xfer_start_bit = serial_control_one[sfd_pkg::CTRL_START];
   wire [1:0] xfer_mode_sel = serial_control_one[sfd_pkg::CTRL_MODE_LO +: 2];
   wire [2:0] sck_sel = serial_control_one[sfd_pkg::CTRL_SCK_LO +: 3];
   wire [1:0] new_mode = reg_wdata[sfd_pkg::CTRL_MODE_LO +: 2];
   wire xfer_abort_bit = wr_ctrl && reg_wdata[sfd_pkg::CTRL_ABORT];

   wire ext_mode = (sck_sel == sfd_pkg::SCK_EXT);
   // mode decides which directions use the buffer
   wire need_rd = (xfer_mode_sel != sfd_pkg::MODE_TX);
   wire need_wr = (xfer_mode_sel != sfd_pkg::MODE_RX);
   wire mode_chg = wr_ctrl && (new_mode != xfer_mode_sel);

   // start only from idle with a usable mode
   wire go = wr_ctrl && reg_wdata[sfd_pkg::CTRL_START] && !xfer_abort_bit
      && (new_mode != sfd_pkg::MODE_RSV) && (state_q == sfd_pkg::ST_IDLE);

   sfd_sync #(
      .W(2)
   ) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .d({serial_clock_pin_i, serial_in_pin}),
      .q({sck_s, si_s})
   );

   sfd_clkgen #(
      .DIV_BASE(DIV_BASE)
   ) u_clkgen (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .run((state_q == sfd_pkg::ST_SHIFT) && !ext_mode),
      .sel(sck_sel),
      .tick(tick)
   );

   // edge events, internal or external
   wire shifting = (state_q == sfd_pkg::ST_SHIFT);
   wire ext_fall = sck_prev_q && !sck_s;
   wire ext_rise = !sck_prev_q && sck_s;
   wire fall_ev = shifting && (ext_mode ? ext_fall : (tick && sck_q));
   wire rise_ev = shifting && (ext_mode ? ext_rise : (tick && !sck_q));
   wire byte_done = rise_ev && (bit_cnt_q == sfd_pkg::LAST_BIT);
   wire [7:0] rx_next = {si_s, rx_shift_q[7:1]};
   // first fall of a byte takes straight from the buffer
   wire out_bit = (bit_cnt_q == 3'h0) ? shared_data_buffer[0] : tx_shift_q[0];
   wire [7:0] tx_rest = (bit_cnt_q == 3'h0) ? {1'b0, shared_data_buffer[7:1]}
      : {1'b0, tx_shift_q[7:1]};
   wire resume = !rd_pend_q && !wr_pend_q;
   wire xfer_end = (state_q != sfd_pkg::ST_IDLE)
      && (state_d == sfd_pkg::ST_IDLE);
   wire [sfd_pkg::IRQ_BITS-1:0] irq_ev = {xfer_end, byte_done};

   always_comb begin
      state_d = state_q;
      case (state_q)
         sfd_pkg::ST_IDLE: begin
            if (go) begin
               state_d = sfd_pkg::ST_SHIFT;
            end
         end
         sfd_pkg::ST_SHIFT: begin
            // a cleared start ends only at byte boundary
            if (byte_done && !xfer_start_bit) begin
               state_d = sfd_pkg::ST_IDLE;
            end else if (byte_done && !ext_mode) begin
               state_d = sfd_pkg::ST_WAIT;
            end
         end
         sfd_pkg::ST_WAIT: begin
            if (!xfer_start_bit) begin
               state_d = sfd_pkg::ST_IDLE;
            end else if (resume) begin
               state_d = sfd_pkg::ST_SHIFT;
            end
         end
         default: begin
            state_d = sfd_pkg::ST_IDLE;
         end
      endcase
      if (xfer_abort_bit) begin
         state_d = sfd_pkg::ST_IDLE;
      end
   end

   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         state_q <= sfd_pkg::ST_IDLE;
         xfer_active_flag <= 1'b0;
         sck_prev_q <= 1'b1;
      end else begin
         state_q <= state_d;
         xfer_active_flag <= (state_d != sfd_pkg::ST_IDLE);
         sck_prev_q <= sck_s;
      end
   end

   // internal clock idles and starts high
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sck_q <= 1'b1;
      end else if (state_d == sfd_pkg::ST_IDLE || ext_mode) begin
         sck_q <= 1'b1;
      end else if (shifting && tick) begin
         sck_q <= !sck_q;
      end
   end

   // shift out on fall, in on rise, lsb first
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         bit_cnt_q <= 3'h0;
         tx_shift_q <= 8'h00;
         rx_shift_q <= 8'h00;
         so_q <= 1'b1;
      end else if (xfer_abort_bit || go) begin
         bit_cnt_q <= 3'h0;
      end else begin
         // serial out changes only on a fall
         if (fall_ev) begin
            so_q <= out_bit;
            tx_shift_q <= tx_rest;
         end
         if (rise_ev) begin
            rx_shift_q <= rx_next;
            bit_cnt_q <= bit_cnt_q + 3'h1;
         end
      end
   end

   // buffer and its service flags; hardware set beats read/write clear, abort clear beats set
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         shared_data_buffer <= sfd_pkg::DATA_RST;
         rd_pend_q <= 1'b0;
         wr_pend_q <= 1'b0;
      end else begin
         if (mode_chg) begin
            shared_data_buffer <= sfd_pkg::DATA_RST;
         end else if (byte_done && need_rd) begin
            shared_data_buffer <= rx_next;
         end else if (wr_data) begin
            shared_data_buffer <= reg_wdata[7:0];
         end
         if (xfer_abort_bit) begin
            rd_pend_q <= 1'b0;
         end else if (byte_done && need_rd) begin
            rd_pend_q <= 1'b1;
         end else if (rd_data) begin
            rd_pend_q <= 1'b0;
         end
         if (xfer_abort_bit) begin
            wr_pend_q <= 1'b0;
         end else if (byte_done && need_wr) begin
            wr_pend_q <= 1'b1;
         end else if (wr_data) begin
            wr_pend_q <= 1'b0;
         end
      end
   end

   // control register; abort is a write pulse and also drops start
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         serial_control_one <= sfd_pkg::CTRL_RST;
      end else if (xfer_abort_bit) begin
         serial_control_one <= reg_wdata[7:0] & sfd_pkg::CTRL_STORE_MASK
            & ~(8'h01 << sfd_pkg::CTRL_START);
      end else if (wr_ctrl) begin
         serial_control_one <= reg_wdata[7:0] & sfd_pkg::CTRL_STORE_MASK;
      end
   end

   // sticky events, set wins over clear
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         irq_stat_q <= '0;
         irq_en_q <= '0;
      end else begin
         irq_stat_q <= (irq_stat_q
            & ~(wr_iclr ? reg_wdata[sfd_pkg::IRQ_BITS-1:0] : '0)) | irq_ev;
         if (wr_ien) begin
            irq_en_q <= reg_wdata[sfd_pkg::IRQ_BITS-1:0];
         end
      end
   end

   wire [7:0] serial_status_reg = {4'h0, wr_pend_q, rd_pend_q,
      state_q == sfd_pkg::ST_WAIT, xfer_active_flag};
   wire [31:0] rd_mux =
      (reg_addr == sfd_pkg::OFS_CTRL) ? {24'h000000, serial_control_one} :
      (reg_addr == sfd_pkg::OFS_DATA) ? {24'h000000, shared_data_buffer} :
      (reg_addr == sfd_pkg::OFS_STAT) ? {24'h000000, serial_status_reg} :
      (reg_addr == sfd_pkg::OFS_ISTAT) ? {30'h00000000, irq_stat_q} :
      (reg_addr == sfd_pkg::OFS_IEN) ? {30'h00000000, irq_en_q} :
      32'h00000000;

   // read data valid the cycle after the strobe only
   always_ff @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 32'h00000000;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

   assign reg_rdata = rdata_q;
   assign buffer_irq = |(irq_stat_q & irq_en_q);
   assign serial_clock_pin_o = sck_q;
   // pin released when clock comes from outside
   assign serial_clock_pin_oe_n = ext_mode;
   assign serial_out_pin = so_q;

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);

   property p_fall_drive;
      fall_ev && !xfer_abort_bit |=> serial_out_pin == $past(out_bit);
   endproperty
   a_fall_drive: assert property (p_fall_drive)
      else $error("serial out not driven on falling edge");

   property p_byte_in;
      byte_done && need_rd && !mode_chg |=> shared_data_buffer == $past(rx_next)
         && irq_stat_q[sfd_pkg::IRQ_BYTE];
   endproperty
   a_byte_in: assert property (p_byte_in)
      else $error("received byte or event missing");

   property p_wait_hold;
      state_q == sfd_pkg::ST_WAIT && !resume && xfer_start_bit
         && !wr_ctrl |=> state_q == sfd_pkg::ST_WAIT && serial_clock_pin_o;
   endproperty
   a_wait_hold: assert property (p_wait_hold)
      else $error("clock left wait before buffer serviced");

   property p_out_only_on_fall;
      !fall_ev |=> $stable(serial_out_pin);
   endproperty
   a_out_only_on_fall: assert property (p_out_only_on_fall)
      else $error("serial out changed without a falling edge");

   property p_finish_byte;
      shifting && !byte_done && !xfer_abort_bit |=> state_q != sfd_pkg::ST_IDLE;
   endproperty
   a_finish_byte: assert property (p_finish_byte)
      else $error("transfer stopped mid byte");

   property p_abort;
      xfer_abort_bit |=> !xfer_active_flag && state_q == sfd_pkg::ST_IDLE;
   endproperty
   a_abort: assert property (p_abort)
      else $error("abort did not stop transfer");

   property p_stop_clears;
      byte_done && !xfer_start_bit && !wr_ctrl |=> !xfer_active_flag
         ##1 !xfer_active_flag;
   endproperty
   a_stop_clears: assert property (p_stop_clears)
      else $error("active flag not cleared after stop");

   property p_mode_clear;
      mode_chg |=> shared_data_buffer == sfd_pkg::DATA_RST;
   endproperty
   a_mode_clear: assert property (p_mode_clear)
      else $error("buffer survived a mode change");

   property p_idle_hold;
      state_q == sfd_pkg::ST_IDLE [*2] |-> $stable(serial_out_pin);
   endproperty
   a_idle_hold: assert property (p_idle_hold)
      else $error("serial out moved while idle");

   property p_pin_dir;
      serial_clock_pin_oe_n == (sck_sel == sfd_pkg::SCK_EXT);
   endproperty
   a_pin_dir: assert property (p_pin_dir)
      else $error("clock pin direction wrong");

   property p_start_high;
      go |=> serial_clock_pin_o ##1 (serial_clock_pin_o || ext_mode);
   endproperty
   a_start_high: assert property (p_start_high)
      else $error("clock pin not high at start");

   property p_active_set;
      go |=> xfer_active_flag;
   endproperty
   a_active_set: assert property (p_active_set)
      else $error("active flag not set at start");
endmodule : sfd_top
`default_nettype wire

// ### testbench/sfd_peer.sv
// serial peer model on the far side of the link pins
`timescale 1ns/1ns
`default_nettype none
module sfd_peer (
   input wire logic sck,
   input wire logic so,
   output logic si,
   output logic sck_drv,
   output logic [7:0] rx_byte
);
   logic [7:0] tx_q;
   int bit_n;
   initial begin
      si = 1'h1;
      sck_drv = 1'h1;
      rx_byte = 8'h00;
      tx_q = 8'h00;
      bit_n = 8;
   end
   task automatic load(input logic [7:0] b);
      tx_q = b;
      bit_n = 0;
   endtask : load
   // drive on fall, lsb first
   // idle line shows the inverse, so stale data never passes
   always @(negedge sck) begin
      if (bit_n < 8) begin
         si = tx_q[bit_n];
         bit_n++;
      end else begin
         si = ~si;
      end
   end
   always @(posedge sck) begin
      rx_byte = {so, rx_byte[7:1]};
   end
   // one frame, clock still between frames
   task automatic frame;
      // edges land off the system clock edge
      #1;
      repeat (8) begin
         #24 sck_drv = 1'h0;
         #24 sck_drv = 1'h1;
      end
   endtask : frame
endmodule : sfd_peer
`default_nettype wire

// ### testbench/test_sfd_top.sv
// self-checking bench for the serial full-duplex transfer unit
`timescale 1ns/1ns
`default_nettype none
module test_sfd_top;
   logic clk_sys = 1'h0;
   logic rstn = 1'h0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0;
   logic reg_wr = 1'h0;
   logic reg_rd = 1'h0;
   logic [31:0] reg_rdata;
   logic buffer_irq, sck_o, sck_oe_n, so, si, sck_drv;
   logic [7:0] rx_byte;
   wire logic sck_w;
   int failures = 0;
   int comparisons = 0;

   always #2 clk_sys = ~clk_sys;
   // released clock pin follows the peer
   assign sck_w = sck_oe_n ? sck_drv : sck_o;

   sfd_top #(.DIV_BASE(4)) i_sfd_top (.clk_sys(clk_sys), .rstn(rstn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .buffer_irq(buffer_irq),
      .serial_clock_pin_i(sck_w), .serial_clock_pin_o(sck_o),
      .serial_clock_pin_oe_n(sck_oe_n), .serial_out_pin(so),
      .serial_in_pin(si));
   sfd_peer i_sfd_peer (.sck(sck_w), .so(so), .si(si), .sck_drv(sck_drv),
      .rx_byte(rx_byte));

   function automatic logic [7:0] ctl(input logic st, input logic ab,
      input sfd_pkg::sfd_mode_t m, input logic [2:0] sel);
      return {st, ab, m, 1'h0, sel};
   endfunction : ctl

   task automatic chk(input string nm, input logic [31:0] got,
      input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      reg_addr <= a;
      reg_wdata <= {24'h0, v};
      reg_wr <= 1'h1;
      @(posedge clk_sys);
      reg_wr <= 1'h0;
      // idle cycle so a following call never re-raises the strobe
      @(posedge clk_sys);
   endtask : wr

   task automatic rdc(input logic [7:0] a, input logic [31:0] m,
      input logic [31:0] e, input string nm);
      reg_addr <= a;
      reg_rd <= 1'h1;
      @(posedge clk_sys);
      reg_rd <= 1'h0;
      #1 chk(nm, reg_rdata & m, e);
      @(posedge clk_sys);
   endtask : rdc

   // bounded wait; a miss counts as a mismatch
   task automatic wait_irq;
      int n;
      n = 0;
      @(posedge clk_sys);
      while (buffer_irq !== 1'h1 && n < 2000) begin
         @(posedge clk_sys);
         n++;
      end
      chk("irq_wait", {31'h0, n < 2000}, 32'h1);
   endtask : wait_irq

   task automatic summarize;
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   initial begin
      #40000;
      failures++;
      $display("mismatch watchdog expected done seen hang");
      summarize();
   end

   initial begin
      repeat (2) @(posedge clk_sys);
      rstn <= 1'h1;
      @(posedge clk_sys);
      #1 chk("sck_rst", sck_o, 1'h1);
      chk("oe_rst", sck_oe_n, 1'h0); // internal after reset
      chk("irq_rst", buffer_irq, 1'h0);
      @(posedge clk_sys);
      rdc(sfd_pkg::OFS_CTRL, 32'hFFFFFFFF, 32'h0, "ctrl_rst");
      rdc(sfd_pkg::OFS_STAT, 32'hFFFFFFFF, 32'h0, "stat_rst");
      wr(8'h18, 8'hFF);
      rdc(8'h18, 32'hFFFFFFFF, 32'h0, "unmapped");
      $display("test reset done");

      wr(sfd_pkg::OFS_IEN, 8'h03);
      i_sfd_peer.load(8'h3C);
      wr(sfd_pkg::OFS_CTRL, ctl(1'h0, 1'h0, sfd_pkg::MODE_TRX, 3'h1));
      wr(sfd_pkg::OFS_DATA, 8'hA5); // data before start
      wr(sfd_pkg::OFS_CTRL, ctl(1'h1, 1'h0, sfd_pkg::MODE_TRX, 3'h1));
      #1 chk("sck_start", sck_o, 1'h1); // pin high at start
      chk("so_hold", so, 1'h1); // old last bit
      @(posedge clk_sys);
      rdc(sfd_pkg::OFS_STAT, 32'h1, 32'h1, "active_set"); // active
      wait_irq();
      chk("peer_rx1", rx_byte, 8'hA5); // lsb first out
      rdc(sfd_pkg::OFS_ISTAT, 32'h1, 32'h1, "byte_evt"); // event
      rdc(sfd_pkg::OFS_STAT, 32'h2, 32'h2, "waiting"); // wait state
      i_sfd_peer.load(8'hC3);
      rdc(sfd_pkg::OFS_DATA, 32'hFF, 32'h3C, "rx1"); // read first
      repeat (40) @(posedge clk_sys);
      #1 chk("sck_park", sck_o, 1'h1); // still needs the write
      @(posedge clk_sys);
      wr(sfd_pkg::OFS_ICLR, 8'h01);
      #1 chk("irq_clr", buffer_irq, 1'h0);
      @(posedge clk_sys);
      wr(sfd_pkg::OFS_DATA, 8'h5A); // write after read
      wr(sfd_pkg::OFS_CTRL, ctl(1'h0, 1'h0, sfd_pkg::MODE_TRX, 3'h1));
      wait_irq();
      repeat (3) @(posedge clk_sys);
      rdc(sfd_pkg::OFS_STAT, 32'h1, 32'h0, "active_end"); // cleared
      rdc(sfd_pkg::OFS_ISTAT, 32'h3, 32'h3, "end_evt"); // end event
      rdc(sfd_pkg::OFS_DATA, 32'hFF, 32'hC3, "rx2"); // byte finished
      chk("peer_rx2", rx_byte, 8'h5A); // second byte
      repeat (40) @(posedge clk_sys);
      #1 chk("so_keep", so, 1'h0); // last bit kept
      chk("sck_idle", sck_o, 1'h1);
      @(posedge clk_sys);
      wr(sfd_pkg::OFS_ICLR, 8'h03);
      $display("test duplex done");

      wr(sfd_pkg::OFS_DATA, 8'hFF);
      wr(sfd_pkg::OFS_CTRL, ctl(1'h1, 1'h0, sfd_pkg::MODE_TRX, 3'h1));
      repeat (3) @(posedge clk_sys);
      #1 chk("so_prev", so, 1'h0); // previous last bit
      repeat (30) @(posedge clk_sys);
      wr(sfd_pkg::OFS_CTRL, ctl(1'h0, 1'h1, sfd_pkg::MODE_TRX, 3'h1));
      rdc(sfd_pkg::OFS_STAT, 32'h1, 32'h0, "active_abort"); // at once
      repeat (200) @(posedge clk_sys);
      rdc(sfd_pkg::OFS_ISTAT, 32'h1, 32'h0, "no_byte"); // no byte
      wr(sfd_pkg::OFS_DATA, 8'h77);
      wr(sfd_pkg::OFS_CTRL, ctl(1'h0, 1'h0, sfd_pkg::MODE_RX, 3'h1));
      rdc(sfd_pkg::OFS_DATA, 32'hFF, 32'h00, "buf_mode");
      wr(sfd_pkg::OFS_CTRL, ctl(1'h0, 1'h0, sfd_pkg::MODE_TX, 3'h1));
      $display("test abort done");

      wr(sfd_pkg::OFS_ICLR, 8'h03);
      wr(sfd_pkg::OFS_DATA, 8'hE1);
      wr(sfd_pkg::OFS_CTRL, ctl(1'h1, 1'h0, sfd_pkg::MODE_TX, 3'h1));
      wr(sfd_pkg::OFS_CTRL, ctl(1'h0, 1'h0, sfd_pkg::MODE_TX, 3'h1));
      wait_irq();
      chk("peer_tx", rx_byte, 8'hE1); // transmit-only out
      rdc(sfd_pkg::OFS_STAT, 32'hF, 32'h8, "tx_stat");
      rdc(sfd_pkg::OFS_DATA, 32'hFF, 32'hE1, "tx_keep"); // no rx
      wr(sfd_pkg::OFS_ICLR, 8'h03);
      $display("test transmit done");

      wr(sfd_pkg::OFS_IEN, 8'h00);
      wr(sfd_pkg::OFS_CTRL, ctl(1'h0, 1'h0, sfd_pkg::MODE_TRX, 3'h7));
      #1 chk("oe_ext", sck_oe_n, 1'h1); // pin released
      @(posedge clk_sys);
      wr(sfd_pkg::OFS_DATA, 8'h96);
      wr(sfd_pkg::OFS_CTRL, ctl(1'h1, 1'h0, sfd_pkg::MODE_TRX, 3'h7));
      i_sfd_peer.load(8'h69);
      i_sfd_peer.frame();
      repeat (10) @(posedge clk_sys);
      #1 chk("irq_mask", buffer_irq, 1'h0);
      @(posedge clk_sys);
      rdc(sfd_pkg::OFS_ISTAT, 32'h1, 32'h1, "ext_byte"); // ext shift
      rdc(sfd_pkg::OFS_DATA, 32'hFF, 32'h69, "ext_rx"); // in time
      chk("peer_rx3", rx_byte, 8'h96); // ext byte out
      wr(sfd_pkg::OFS_IEN, 8'h01);
      #1 chk("irq_on", buffer_irq, 1'h1);
      @(posedge clk_sys);
      wr(sfd_pkg::OFS_CTRL, ctl(1'h0, 1'h1, sfd_pkg::MODE_TRX, 3'h7));
      rdc(sfd_pkg::OFS_STAT, 32'h1, 32'h0, "ext_abort"); // stopped
      $display("test external done");
      summarize();
   end
endmodule : test_sfd_top
`default_nettype wire
